// [hdl/master_i2c_block_loader.sv]
`timescale 1ns/10ps
module master_i2c_block_loader
  import loader_pkg::*;
(
  input  wire logic     REF_CLK,
  input  wire logic     RST,
  input  wire logic     SCL_IN,
  output logic          SCL_OUT,
  output logic          SCL_OE_N,
  input  wire logic     SDA_IN,
  output logic          SDA_OUT,
  output logic          SDA_OE_N,
  output logic          WR_VALID,
  input  wire logic     WR_READY,
  output wr_word_s      WR_WORD,
  output logic          BUSY,
  output logic          DONE,
  output logic          ERROR
);

  ldr_state_s  s_reg, s_next;
  wr_word_s    buf_in;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        tick;
  logic        adv;
  logic [1:0]  pin_in;
  logic [7:0]  rxb;
  logic [15:0] len_full;

  assign pin_in   = {SDA_IN, SCL_IN};
  assign SCL_OUT  = s_reg.pin_lvl;
  assign SDA_OUT  = s_reg.pin_lvl;
  assign SCL_OE_N = s_reg.scl_oe_n;
  assign SDA_OE_N = s_reg.sda_oe_n;
  assign BUSY     = s_reg.busy;
  assign DONE     = s_reg.done;
  assign ERROR    = s_reg.err;

  // level to put on sda for a bit slot
  function automatic logic sda_level(input logic       rd,
                                     input logic [3:0] bitn,
                                     input logic [7:0] sh,
                                     input logic       nack);
    if (bitn == 4'h8) begin
      return rd ? nack : 1'b1;
    end
    return rd ? 1'b1 : sh[7];
  endfunction

  always_comb begin
    s_next       = s_reg;
    buf_in_valid = 1'b0;
    rxb          = s_reg.sh;
    len_full     = {s_reg.total[15:8], rxb};
    buf_in       = '{mem: s_reg.mem[2:0], addr: s_reg.addr, lane: s_reg.lane, data: s_reg.sh};
    tick         = (s_reg.qcnt == QTR_LAST);
    adv          = tick && (s_reg.q != 2'h1 || s_reg.filt[PIN_SCL]);

    // pin synchronisers and spike filter
    for (int i = 0; i < 2; i++) begin
      s_next.sync[i] = {s_reg.sync[i][1:0], pin_in[i]};
      if (s_reg.sync[i][2] != s_reg.sync[i][1] || s_reg.sync[i][2] == s_reg.filt[i]) begin
        s_next.fcnt[i] = 2'h0;
      end else if (s_reg.fcnt[i] == SPIKE_LAST) begin
        s_next.filt[i] = s_reg.sync[i][2];
        s_next.fcnt[i] = 2'h0;
      end else begin
        s_next.fcnt[i] = s_reg.fcnt[i] + 2'h1;
      end
    end

    // quarter period timer, held while a slave stretches scl
    if (adv) begin
      s_next.qcnt = 5'h00;
    end else if (!tick) begin
      s_next.qcnt = s_reg.qcnt + 5'h01;
    end

    case (s_reg.st)
      ST_IDLE: begin
        s_next.st       = ST_START;
        s_next.busy     = 1'b1;
        s_next.seq      = SEQ_START;
        s_next.q        = 2'h0;
        s_next.qcnt     = 5'h00;
        s_next.sda_oe_n = 1'b1;
      end
      ST_START: begin
        if (adv) begin
          s_next.q = s_reg.q + 2'h1;
          case (s_reg.q)
            2'h0: s_next.scl_oe_n = 1'b1;
            2'h1: s_next.sda_oe_n = 1'b0;
            2'h2: s_next.scl_oe_n = 1'b0;
            default: begin
              s_next.st       = ST_BYTE;
              s_next.rd       = 1'b0;
              s_next.bitn     = 4'h0;
              s_next.sh       = {MEM_DEV_ADDR, s_reg.seq == SEQ_RESTART};
              s_next.seq      = s_reg.seq + 3'h1;
              s_next.sda_oe_n = sda_level(1'b0, 4'h0, s_next.sh, 1'b0);
            end
          endcase
        end
      end
      ST_BYTE: begin
        if (adv) begin
          s_next.q = s_reg.q + 2'h1;
          case (s_reg.q)
            2'h0: s_next.scl_oe_n = 1'b1;
            2'h1: begin
              if (s_reg.bitn == 4'h8) begin
                s_next.nak_in = s_reg.filt[PIN_SDA];
              end else begin
                s_next.sh = {s_reg.sh[6:0], s_reg.filt[PIN_SDA]};
              end
            end
            2'h2: s_next.scl_oe_n = 1'b0;
            default: begin
              if (s_reg.bitn != 4'h8) begin
                s_next.bitn     = s_reg.bitn + 4'h1;
                s_next.sda_oe_n = sda_level(s_reg.rd, s_next.bitn, s_reg.sh, s_reg.last);
              end else if (s_reg.rd) begin
                s_next.st = s_reg.last ? ST_STOP : ST_PARSE;
              end else if (s_reg.nak_in) begin
                s_next.err = 1'b1;
                s_next.st  = ST_STOP;
              end else if (s_reg.seq == SEQ_PTR_HI || s_reg.seq == SEQ_PTR_LO) begin
                s_next.seq      = s_reg.seq + 3'h1;
                s_next.bitn     = 4'h0;
                s_next.sh       = MEM_PTR_BYTE;
                s_next.sda_oe_n = sda_level(1'b0, 4'h0, MEM_PTR_BYTE, 1'b0);
              end else if (s_reg.seq == SEQ_RESTART) begin
                s_next.st       = ST_START;
                s_next.sda_oe_n = 1'b1;
              end else begin
                s_next.seq      = SEQ_READ;
                s_next.rd       = 1'b1;
                s_next.bitn     = 4'h0;
                s_next.sda_oe_n = 1'b1;
              end
              if (s_next.st == ST_STOP) begin
                s_next.sda_oe_n = 1'b0;
              end
            end
          endcase
        end
      end
      ST_PARSE: begin
        s_next.st       = ST_BYTE;
        s_next.rd       = 1'b1;
        s_next.bitn     = 4'h0;
        s_next.q        = 2'h0;
        s_next.qcnt     = 5'h00;
        s_next.sda_oe_n = 1'b1;
        s_next.ofs      = s_reg.ofs + 16'h0001;
        if (s_reg.ofs >= OFS_ID_HI
            && (s_reg.ofs < HDR_LEN || s_reg.ofs < s_reg.total - TRAIL_LEN)) begin
          s_next.sum = s_reg.sum + {8'h00, rxb};
        end
        case (s_reg.ofs)
          OFS_CKS_HI:  s_next.cks[15:8]   = rxb;
          OFS_CKS_LO:  s_next.cks[7:0]    = rxb;
          OFS_ID_HI:   s_next.id[15:8]    = rxb;
          OFS_ID_LO:   s_next.id[7:0]     = rxb;
          OFS_MEM:     s_next.mem         = rxb;
          OFS_ADDR_HI: s_next.addr[15:8]  = rxb;
          OFS_ADDR_LO: s_next.addr[7:0]   = rxb;
          OFS_LEN_HI:  s_next.total[15:8] = rxb;
          OFS_LEN_LO: begin
            s_next.total[7:0] = rxb;
            s_next.lane       = 3'h0;
            if (s_reg.id != HDR_ID) begin
              s_next.err  = 1'b1;
              s_next.last = 1'b1;
            end else if (s_reg.mem == MEM_CPU_PROG && s_reg.addr == 16'h0000
                         && len_full == 16'h0000) begin
              s_next.last = 1'b1;
            end else if (s_reg.mem > MEM_DSP_DATA || len_full < HDR_LEN + TRAIL_LEN) begin
              s_next.err  = 1'b1;
              s_next.last = 1'b1;
            end
          end
          default: begin
            // offsets 5, 10 and 11 are skipped
            if (s_reg.ofs >= HDR_LEN && s_reg.ofs < s_reg.total - TRAIL_LEN) begin
              s_next.st = ST_PUSH;
            end else if (s_reg.ofs == s_reg.total - 16'h0001) begin
              s_next.ofs = 16'h0000;
              s_next.sum = 16'h0000;
              if (s_reg.sum != s_reg.cks) begin
                s_next.err  = 1'b1;
                s_next.last = 1'b1;
              end
            end
          end
        endcase
        s_next.sda_oe_n = sda_level(1'b1, 4'h0, rxb, s_next.last);
      end
      ST_PUSH: begin
        buf_in_valid = 1'b1;
        if (buf_in_ready) begin
          s_next.st = ST_BYTE;
          if (s_reg.mem == MEM_DSP_PROG && s_reg.lane != DSP_LANE_LAST) begin
            s_next.lane = s_reg.lane + 3'h1;
          end else begin
            s_next.lane = 3'h0;
            s_next.addr = s_reg.addr + 16'h0001;
          end
        end
      end
      ST_STOP: begin
        if (adv) begin
          s_next.q = s_reg.q + 2'h1;
          case (s_reg.q)
            2'h0: s_next.scl_oe_n = 1'b1;
            2'h1: s_next.sda_oe_n = 1'b1;
            2'h2: s_next.st       = ST_END;
            default: s_next.st    = ST_END;
          endcase
        end
      end
      ST_END: begin
        s_next.busy     = 1'b0;
        s_next.done     = ~s_reg.err;
        s_next.scl_oe_n = 1'b1;
        s_next.sda_oe_n = 1'b1;
        s_next.qcnt     = 5'h00;
      end
      default: s_next = LDR_RESET;
    endcase

    if (s_reg.st != s_next.st && s_next.st != ST_PUSH) begin
      s_next.q    = 2'h0;
      s_next.qcnt = 5'h00;
    end
    s_next.pin_lvl = 1'b0;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_reg <= LDR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  pair_buffer u_buf (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (WR_WORD)
  );

endmodule

// [hdl/loader_pkg.sv]
package loader_pkg;

  // timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_MAX_HZ    = 375_000;
  localparam int SPIKE_NS      = 50;
  localparam int QTR_CYC_I     = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam int SPIKE_CYC_I   = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] QTR_LAST   = 5'(QTR_CYC_I - 1);
  localparam logic [1:0] SPIKE_LAST = 2'(SPIKE_CYC_I - 1);

  // serial memory; value arbitrary
  localparam logic [6:0] MEM_DEV_ADDR = 7'h50;
  localparam logic [7:0] MEM_PTR_BYTE = 8'h00;

  // pin index
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;

  // block header layout
  localparam logic [15:0] OFS_CKS_HI  = 16'h0000;
  localparam logic [15:0] OFS_CKS_LO  = 16'h0001;
  localparam logic [15:0] OFS_ID_HI   = 16'h0002;
  localparam logic [15:0] OFS_ID_LO   = 16'h0003;
  localparam logic [15:0] OFS_MEM     = 16'h0004;
  localparam logic [15:0] OFS_ADDR_HI = 16'h0006;
  localparam logic [15:0] OFS_ADDR_LO = 16'h0007;
  localparam logic [15:0] OFS_LEN_HI  = 16'h0008;
  localparam logic [15:0] OFS_LEN_LO  = 16'h0009;
  localparam logic [15:0] HDR_LEN     = 16'h000c;
  localparam logic [15:0] TRAIL_LEN   = 16'h0004;
  localparam logic [15:0] HDR_ID      = 16'h001f;

  // memory select codes
  localparam logic [7:0] MEM_CPU_PROG  = 8'h00;
  localparam logic [7:0] MEM_CPU_XDATA = 8'h01;
  localparam logic [7:0] MEM_DSP_PROG  = 8'h02;
  localparam logic [7:0] MEM_DSP_COEF  = 8'h03;
  localparam logic [7:0] MEM_DSP_DATA  = 8'h04;
  localparam logic [2:0] DSP_LANE_LAST = 3'h6;

  // fetch sequence
  localparam logic [2:0] SEQ_START   = 3'h0;
  localparam logic [2:0] SEQ_PTR_HI  = 3'h1;
  localparam logic [2:0] SEQ_PTR_LO  = 3'h2;
  localparam logic [2:0] SEQ_RESTART = 3'h3;
  localparam logic [2:0] SEQ_DEV_RD  = 3'h4;
  localparam logic [2:0] SEQ_READ    = 3'h5;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_BYTE  = 3'b010,
    ST_PARSE = 3'b011,
    ST_PUSH  = 3'b100,
    ST_STOP  = 3'b101,
    ST_END   = 3'b110
  } ctl_e;

  typedef struct packed {
    logic [2:0]  mem;
    logic [15:0] addr;
    logic [2:0]  lane;
    logic [7:0]  data;
  } wr_word_s;

  typedef struct packed {
    ctl_e            st;
    logic [2:0]      seq;
    logic            rd;
    logic            last;
    logic [4:0]      qcnt;
    logic [1:0]      q;
    logic [3:0]      bitn;
    logic [7:0]      sh;
    logic            nak_in;
    logic [1:0][2:0] sync;
    logic [1:0]      filt;
    logic [1:0][1:0] fcnt;
    logic            scl_oe_n;
    logic            sda_oe_n;
    logic            pin_lvl;
    logic [15:0]     ofs;
    logic [15:0]     cks;
    logic [15:0]     sum;
    logic [15:0]     id;
    logic [7:0]      mem;
    logic [15:0]     addr;
    logic [15:0]     total;
    logic [2:0]      lane;
    logic            busy;
    logic            done;
    logic            err;
  } ldr_state_s;

  localparam ldr_state_s LDR_RESET = '{st: ST_IDLE, sync: '1, filt: '1, scl_oe_n: 1'b1,
                                       sda_oe_n: 1'b1, default: '0};

  typedef struct packed {
    wr_word_s [1:0] ent;
    logic [1:0]     vld;
  } buf_state_s;

  localparam buf_state_s BUF_RESET = '{default: '0};

endpackage

// [hdl/pair_buffer.sv]
`timescale 1ns/10ps
module pair_buffer
  import loader_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     in_valid,
  output logic          in_ready,
  input  wire wr_word_s in_data,
  output logic          out_valid,
  input  wire logic     out_ready,
  output wr_word_s      out_data
);

  buf_state_s b_reg, b_next;
  logic       pop;
  logic       push;

  assign in_ready  = ~b_reg.vld[1];
  assign out_valid = b_reg.vld[0];
  assign out_data  = b_reg.ent[0];

  always_comb begin
    b_next = b_reg;
    pop    = b_reg.vld[0] & out_ready;
    push   = in_valid & ~b_reg.vld[1];
    if (pop) begin
      b_next.ent[0] = b_reg.ent[1];
      b_next.vld    = {1'b0, b_reg.vld[1]};
    end
    if (push) begin
      if (b_next.vld[0]) begin
        b_next.ent[1] = in_data;
        b_next.vld[1] = 1'b1;
      end else begin
        b_next.ent[0] = in_data;
        b_next.vld[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_reg <= BUF_RESET;
    end else begin
      b_reg <= b_next;
    end
  end

endmodule

// [verif/loader_sva.sv]
`timescale 1ns/10ps
module loader_sva
  import loader_pkg::*;
(
  input wire logic     REF_CLK,
  input wire logic     RST,
  input wire logic     SCL_IN,
  input wire logic     SCL_OUT,
  input wire logic     SCL_OE_N,
  input wire logic     SDA_IN,
  input wire logic     SDA_OUT,
  input wire logic     SDA_OE_N,
  input wire logic     WR_VALID,
  input wire logic     WR_READY,
  input wire wr_word_s WR_WORD,
  input wire logic     BUSY,
  input wire logic     DONE,
  input wire logic     ERROR
);
  logic [6:0] per_cnt;
  logic       per_seen;

  // cycles since the last scl release
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      per_cnt  <= 7'h00;
      per_seen <= 1'b0;
    end else if ($rose(SCL_OE_N)) begin
      per_cnt  <= 7'h01;
      per_seen <= 1'b1;
    end else if (per_cnt != 7'h7f) begin
      per_cnt <= per_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  excl_flags_a: assert property (!(DONE && ERROR))
    else $error("done and error both high");
  pins_low_a: assert property (!SCL_OUT && !SDA_OUT)
    else $error("pin output value not low");
  word_hold_a: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_WORD))
    else $error("stalled word changed");
  mem_code_a: assert property (WR_VALID |-> WR_WORD.mem <= 3'h4)
    else $error("word routed to reserved memory");
  lane_range_a: assert property (WR_VALID |->
    (WR_WORD.mem == 3'h2 ? WR_WORD.lane <= 3'h6 : WR_WORD.lane == 3'h0))
    else $error("lane out of range");
  done_stick_a: assert property (DONE |=> DONE)
    else $error("done dropped");
  err_stick_a: assert property (ERROR |=> ERROR)
    else $error("error dropped");
  scl_rate_a: assert property ($rose(SCL_OE_N) && per_seen |-> per_cnt >= 7'h43)
    else $error("serial clock too fast");
  idle_free_a: assert property (!BUSY |-> SCL_OE_N && SDA_OE_N)
    else $error("bus held while idle");
  end_flag_a: assert property ($fell(BUSY) |-> DONE || ERROR)
    else $error("busy fell without outcome");

  cover property ($rose(DONE));
  cover property ($rose(ERROR));
  cover property (WR_VALID && !WR_READY [*8]);
  cover property (WR_VALID && WR_READY && WR_WORD.lane == 3'h6);
endmodule

bind master_i2c_block_loader loader_sva u_sva (.REF_CLK, .RST, .SCL_IN, .SCL_OUT, .SCL_OE_N,
  .SDA_IN, .SDA_OUT, .SDA_OE_N, .WR_VALID, .WR_READY, .WR_WORD, .BUSY, .DONE, .ERROR);

// [verif/serial_mem_model.sv]
`timescale 1ns/10ps
module serial_mem_model
  import loader_pkg::*;
(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic refuse,
  input  wire logic slow,
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  logic [7:0]  mem [256];
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        act;
  logic        rd;
  int          bitc;
  int          nbyte;

  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    act = 1'b0;
    rd = 1'b0;
  end
  // start and stop
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    bitc = -1;
    nbyte = 0;
    rd = 1'b0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (bitc < 8 && !rd) sh = {sh[6:0], sda};
    else if (bitc == 8 && rd && nbyte > 0 && sda) act = 1'b0;
  end
  // ack slots and sequential read data
  always @(negedge scl) if (act) begin
    bitc = bitc + 1;
    if (bitc == 8 && !rd) begin
      if (nbyte == 0) begin
        rd = sh[0];
        sda_oe_n = !(sh[7:1] == MEM_DEV_ADDR && !refuse);
      end else begin
        ptr = (nbyte == 1) ? {sh, ptr[7:0]} : {ptr[15:8], sh};
        sda_oe_n = 1'b0;
      end
    end else if (bitc == 8) sda_oe_n = 1'b1;
    else if (bitc == 9) begin
      bitc = 0;
      nbyte = nbyte + 1;
      if (rd) begin
        sh = mem[ptr[7:0]];
        ptr = ptr + 16'h0001;
      end
      sda_oe_n = rd ? sh[7] : 1'b1;
      // stretch only once sda is settled, so the scl release is no start or stop
      if (slow) begin
        scl_oe_n = 1'b0;
        #2000 scl_oe_n = 1'b1;
      end
    end else if (rd && nbyte > 0) sda_oe_n = sh[7 - bitc];
  end
endmodule

// [verif/test_master_i2c_block_loader.sv]
`timescale 1ns/10ps
module test_master_i2c_block_loader
  import loader_pkg::*;
;
  logic     ref_clk, rst, wr_ready, refuse, slow, spike, spike_on;
  logic     scl_oe_n, sda_oe_n, mem_scl_oe_n, mem_sda_oe_n, wr_valid, busy, done, error;
  wire      scl_w = scl_oe_n & mem_scl_oe_n;
  wire      sda_w = sda_oe_n & mem_sda_oe_n;
  wr_word_s wr_word;
  wr_word_s exp_q[$];
  wr_word_s got_q[$];
  int       num_errors, checked, pos, spk_cnt;

  master_i2c_block_loader u_dut (.REF_CLK(ref_clk), .RST(rst), .SCL_IN(scl_w), .SCL_OUT(),
    .SCL_OE_N(scl_oe_n), .SDA_IN(sda_w & ~spike), .SDA_OUT(), .SDA_OE_N(sda_oe_n),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_WORD(wr_word), .BUSY(busy),
    .DONE(done), .ERROR(error));
  serial_mem_model u_mem (.scl(scl_w), .sda(sda_w), .refuse(refuse), .slow(slow),
    .scl_oe_n(mem_scl_oe_n), .sda_oe_n(mem_sda_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (wr_valid && wr_ready) got_q.push_back(wr_word);
  // one-cycle glitch every 97 cycles
  always @(negedge ref_clk) begin
    spk_cnt <= spk_cnt + 1;
    spike <= spike_on && (spk_cnt % 97 == 0);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic timeout;
    num_errors++;
    $display("timeout waiting on loader");
    tally_and_finish;
  endtask

  task automatic prep;
    int i;
    rst = 1'b1;
    for (i = 0; i < 256; i++) u_mem.mem[i] = 8'h00;
    pos = 0;
    exp_q = {};
    got_q = {};
  endtask

  task automatic go;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  // block image plus expected words; unused header bytes stay zero
  task automatic put_block(input logic [7:0] sel, input logic [15:0] sa, input int n,
                           input logic [7:0] d0, input logic [15:0] cks_err);
    logic [15:0] t, s;
    logic [7:0]  h [12];
    wr_word_s    w;
    int          i;
    t = 16'(n + 16);
    h = '{8'h00, 8'h00, 8'h00, 8'h1f, sel, 8'h00, sa[15:8], sa[7:0], t[15:8], t[7:0],
          8'h00, 8'h00};
    s = 16'h0000;
    for (i = 2; i < 12; i++) s += 16'(h[i]);
    for (i = 0; i < n; i++) begin
      s += 16'(d0 + 8'(i));
      u_mem.mem[pos + 12 + i] = d0 + 8'(i);
      w.mem = sel[2:0];
      w.data = d0 + 8'(i);
      w.lane = (sel == 8'h02) ? 3'(i % 7) : 3'h0;
      w.addr = sa + 16'((sel == 8'h02) ? i / 7 : i);
      exp_q.push_back(w);
    end
    s ^= cks_err;
    h[0] = s[15:8];
    h[1] = s[7:0];
    for (i = 0; i < 12; i++) u_mem.mem[pos + i] = h[i];
    pos += n + 16;
  endtask

  task automatic finish_dl(input logic exp_done, input logic exp_err);
    int k;
    for (k = 0; k < 80000 && busy !== 1'b0; k++) @(negedge ref_clk);
    if (k == 80000) timeout;
    check("done", 32'(done), 32'(exp_done));
    check("error", 32'(error), 32'(exp_err));
  endtask

  task automatic t_full;
    int i, k;
    prep;
    put_block(8'h02, 16'h0120, 7, 8'h31, 16'h0000);
    put_block(8'h00, 16'h0010, 1, 8'h42, 16'h0000);
    put_block(8'h01, 16'h0200, 1, 8'h53, 16'h0000);
    put_block(8'h03, 16'h0030, 1, 8'h64, 16'h0000);
    put_block(8'h04, 16'h0040, 1, 8'h75, 16'h0000);
    u_mem.mem[pos + 3] = 8'h1f;
    wr_ready = 1'b0;
    spike_on = 1'b1;
    go;
    check("busy after release", 32'(busy), 32'h1);
    for (k = 0; k < 20000 && wr_valid !== 1'b1; k++) @(negedge ref_clk);
    if (k == 20000) timeout;
    repeat (2000) @(negedge ref_clk);
    check("scl held in stall", 32'(scl_oe_n), 32'h0);
    check("words in stall", 32'(got_q.size()), 32'h0);
    wr_ready = 1'b1;
    finish_dl(1'b1, 1'b0);
    spike_on = 1'b0;
    check("word count", 32'(got_q.size()), 32'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      check("word", 32'(got_q[i]), 32'(exp_q[i]));
    end
    $display("test full image done");
  endtask

  task automatic t_bad_id;
    prep;
    put_block(8'h01, 16'h0000, 1, 8'h11, 16'h0000);
    u_mem.mem[3] = 8'h1e;
    go;
    finish_dl(1'b0, 1'b1);
    check("words after bad id", 32'(got_q.size()), 32'h0);
    $display("test bad identifier done");
  endtask

  task automatic t_bad_sel;
    prep;
    put_block(8'h05, 16'h0000, 1, 8'h11, 16'h0000);
    go;
    finish_dl(1'b0, 1'b1);
    check("words after reserved code", 32'(got_q.size()), 32'h0);
    $display("test reserved code done");
  endtask

  task automatic t_bad_cks;
    prep;
    slow = 1'b1;
    put_block(8'h04, 16'h0000, 1, 8'h22, 16'h0100);
    go;
    finish_dl(1'b0, 1'b1);
    check("words before checksum", 32'(got_q.size()), 32'h1);
    slow = 1'b0;
    $display("test checksum mismatch done");
  endtask

  task automatic t_nak;
    prep;
    refuse = 1'b1;
    u_mem.mem[3] = 8'h1f;
    go;
    finish_dl(1'b0, 1'b1);
    refuse = 1'b0;
    $display("test address refused done");
  endtask

  initial begin
    rst = 1'b1;
    wr_ready = 1'b1;
    refuse = 1'b0;
    slow = 1'b0;
    spike_on = 1'b0;
    t_full;
    t_bad_id;
    t_bad_sel;
    t_bad_cks;
    t_nak;
    tally_and_finish;
  end
endmodule
